// File: uart_baud_and_line_status_tb.sv
`timescale 1ns/1ns
`default_nettype none
module uart_baud_and_line_status_tb;
  localparam logic [7:0] A_D = ubl_pkg::ADDR_DATA;
  localparam logic [7:0] A_IE = ubl_pkg::ADDR_IEN;
  localparam logic [7:0] A_LC = ubl_pkg::ADDR_LCTL;
  localparam logic [7:0] A_LS = ubl_pkg::ADDR_LSTAT;
  // At 10 MHz a divisor of 12 keeps the bit rate below the allowed top.
  localparam logic [7:0] DIV = 8'h0C;
  localparam int BIT = 16 * DIV;
  logic clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, serial_in, sout, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  ubl_uart_status i_dut (.i_core_clk(clk), .i_resetn(resetn),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(4'h1), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_serial_in(serial_in), .o_serial_out(sout), .o_irq(irq));
  ubl_serial_peer i_peer (.i_core_clk(clk), .o_line(serial_in));
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s,
      input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
      input logic [1:0] er = 2'b00);
    logic ta, tw;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (awvalid && !ta || wvalid && !tw);
    do @(negedge clk); while (!bvalid);
    chk("bresp", bresp, er);
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
      input logic [1:0] er = 2'b00, input logic [7:0] m = 8'hFF);
    logic t;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      t = arready;
      @(posedge clk);
    end while (!t);
    arvalid <= 1'b0;
    do @(negedge clk); while (!rvalid);
    chk($sformatf("read %h", a), rdata & {24'hFF_FFFF, m}, {24'h00_0000, e});
    chk("rresp", rresp, er);
    @(posedge clk);
    rready <= 1'b0;
  endtask
  task automatic rx(input logic [11:0] b, input int n);
    i_peer.send(b, n, BIT);
    i_peer.hold(1'b1, BIT / 2);
  endtask
  task automatic t_regs;
    rd(A_LS, 8'h60);
    rd(A_LC, 8'h03);
    rd(A_IE, 8'h00);
    rd(8'h08, 8'h00, 2'b10);
    wr(8'h08, 8'hFF, 2'b10);
    wr(A_LS, 8'hFF);
    rd(A_LS, 8'h60);
  endtask
  task automatic t_div;
    wr(A_LC, 8'h83);
    wr(A_D, 8'hA7);
    wr(A_IE, 8'h5C);
    rd(A_D, 8'hA7);
    rd(A_IE, 8'h5C);
    wr(A_D, DIV);
    wr(A_IE, 8'h00);
    wr(A_LC, 8'h03);
    rd(A_IE, 8'h00);
  endtask
  task automatic t_irq;
    wr(A_IE, 8'h02);
    repeat (2) @(negedge clk);
    chk("irq", irq, 1'b1);
    rd(A_LS, 8'h60);
    wr(A_IE, 8'h00);
    repeat (2) @(negedge clk);
    chk("irq", irq, 1'b0);
  endtask
  task automatic t_tx;
    logic [9:0] fr;
    wr(A_D, 8'h4B);
    fork
      begin
        do @(negedge clk); while (sout);
        repeat (BIT / 2) @(negedge clk);
        for (int i = 0; i < 10; i++) begin
          fr[i] = sout;
          repeat (BIT) @(negedge clk);
        end
        chk("tx frame", fr, {1'b1, 8'h4B, 1'b0});
      end
      begin
        wr(A_D, 8'hC3);
        rd(A_LS, 8'h00);
      end
    join
    repeat (12 * BIT) @(posedge clk);
    rd(A_LS, 8'h60);
  endtask
  task automatic t_rx;
    wr(A_LC, 8'h07);
    rx({1'b1, 8'hA5, 1'b0}, 10);
    rd(A_LS, 8'h61);
    rd(A_D, 8'hA5);
    rd(A_LS, 8'h60);
    i_peer.send({1'b1, 8'h11, 1'b0}, 10, BIT);
    rx({1'b1, 8'h22, 1'b0}, 10);
    rd(A_LS, 8'h63);
    rd(A_LS, 8'h61);
    rd(A_D, 8'h22);
    // Five-bit characters, so the short word length is decoded too.
    wr(A_LC, 8'h00);
    rx({1'b1, 5'h15, 1'b0}, 7);
    rd(A_LS, 8'h61);
    rd(A_D, 8'h15);
  endtask
  task automatic t_par;
    wr(A_IE, 8'h04);
    wr(A_LC, 8'h1B);
    rx({2'b10, 8'h01, 1'b0}, 11);
    chk("irq", irq, 1'b1);
    rd(A_LS, 8'h65);
    repeat (2) @(negedge clk);
    chk("irq", irq, 1'b0);
    rd(A_D, 8'h01);
    wr(A_LC, 8'h0B);
    rx({2'b10, 8'h01, 1'b0}, 11);
    rd(A_LS, 8'h61);
    rd(A_D, 8'h01);
    wr(A_IE, 8'h00);
    wr(A_LC, 8'h03);
  endtask
  task automatic t_frame;
    i_peer.send({1'b0, 8'h5A, 1'b0}, 10, BIT);
    i_peer.hold(1'b0, BIT / 2);
    rd(A_LS, 8'h69);
    rd(A_D, 8'h5A);
    i_peer.hold(1'b1, 10 * BIT);
    rd(A_LS, 8'h61);
    rd(A_D, 8'hFF);
  endtask
  task automatic t_brk;
    i_peer.hold(1'b0, 12 * BIT);
    i_peer.hold(1'b1, BIT / 2);
    rd(A_LS, 8'h79);
    rd(A_D, 8'h00);
    rx({1'b1, 8'h3C, 1'b0}, 10);
    rd(A_LS, 8'h61);
    rd(A_D, 8'h3C);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // The ceiling is over twice the expected run of some 25000 cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    resetn = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_div();
    t_irq();
    t_tx();
    t_rx();
    t_par();
    t_frame();
    t_brk();
    test_done();
  end
endmodule // uart_baud_and_line_status_tb
`default_nettype wire

// File: ubl_baud_div.sv
`timescale 1ns/1ns
`default_nettype none
module ubl_baud_div #(
  parameter int WIDTH = 16
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [WIDTH-1:0] i_divisor,
  input wire logic i_reload,
  output logic o_tick
);
  logic [WIDTH-1:0] count;

  // A divisor of one gives a tick on every clock.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count <= {{(WIDTH-1){1'b0}}, 1'b1};
      o_tick <= 1'b0;
    end else if (i_reload) begin
      count <= i_divisor;
      o_tick <= 1'b0;
    end else if (count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
      count <= i_divisor;
      o_tick <= 1'b1;
    end else begin
      count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      o_tick <= 1'b0;
    end
  end
endmodule // ubl_baud_div
`default_nettype wire

// File: ubl_checker.sv
`timescale 1ns/1ns
`default_nettype none
module ubl_checker (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic o_serial_out,
  input wire logic o_irq
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  // Shadow state follows writes when their response is taken, so it lags
  // the block by a cycle; the irq checks allow for that.
  logic [7:0] aw_a, ar_a, w_d;
  logic [15:0] div;
  logic [1:0] ien;
  logic dacc;
  wire logic st_rd = o_rvalid && ar_a == ubl_pkg::ADDR_LSTAT;
  wire logic dv_rd = o_rvalid && dacc && (ar_a == ubl_pkg::ADDR_DATA ||
    ar_a == ubl_pkg::ADDR_IEN);
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aw_a <= 8'h00;
      w_d <= 8'h00;
      ar_a <= 8'h00;
    end else begin
      if (i_awvalid && o_awready) aw_a <= i_awaddr;
      if (i_wvalid && o_wready) w_d <= i_wdata[7:0];
      if (i_arvalid && o_arready) ar_a <= i_araddr;
    end
  end
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dacc <= 1'b0;
      div <= ubl_pkg::DIV_RESET;
      ien <= 2'b00;
    end else if (o_bvalid && i_bready) begin
      if (aw_a == ubl_pkg::ADDR_LCTL) dacc <= w_d[7];
      if (aw_a == ubl_pkg::ADDR_DATA && dacc) div[7:0] <= w_d;
      if (aw_a == ubl_pkg::ADDR_IEN && dacc) div[15:8] <= w_d;
      if (aw_a == ubl_pkg::ADDR_IEN && !dacc) ien <= w_d[2:1];
    end
  end
  chk_stat_msb_zero: assert property (st_rd |-> !o_rdata[7])
    else $error("status bit 7 read as one");
  chk_idle_has_room:
    assert property (st_rd && o_rdata[6] |-> o_rdata[5])
    else $error("idle flag without holding empty");
  chk_idle_line_mark:
    assert property (st_rd && o_rdata[6] |->
      o_serial_out && $past(o_serial_out, 2))
    else $error("idle flag while line active");
  chk_div_readback:
    assert property (dv_rd |-> o_rdata[7:0] ==
      (ar_a == ubl_pkg::ADDR_IEN ? div[15:8] : div[7:0]))
    else $error("divisor byte read back wrong");
  chk_irq_masked:
    assert property (ien == 2'b00 && $past(ien) == 2'b00 |-> !o_irq)
    else $error("irq with all sources disabled");
  chk_irq_holding:
    assert property (st_rd && o_rdata[5] && ien == 2'b01 |-> o_irq)
    else $error("no irq while holding empty enabled");
  chk_irq_errors:
    assert property (st_rd && |o_rdata[4:1] && ien == 2'b10 |-> $past(o_irq))
    else $error("no irq for line error");
  chk_write_answer: assert property (i_awvalid && o_awready |->
    ##[1:4] o_bvalid)
    else $error("write response missing");
  cov_framing: cover property (st_rd && o_rdata[3]);
  cov_break: cover property (st_rd && o_rdata[4]);
  cov_irq: cover property (o_irq);
  cov_parity: cover property (st_rd && o_rdata[2]);
endmodule // ubl_checker
bind ubl_uart_status ubl_checker i_chk (.i_core_clk, .i_resetn, .i_awaddr,
  .i_awvalid, .o_awready, .i_wdata, .i_wvalid, .o_wready, .o_bvalid,
  .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rvalid,
  .o_serial_out, .o_irq);
`default_nettype wire

// File: ubl_pkg.sv
package ubl_pkg;
  // Byte addresses of the register words on the AXI4-Lite bus.
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_IEN = 8'h04;
  localparam logic [7:0] ADDR_LCTL = 8'h0C;
  localparam logic [7:0] ADDR_LSTAT = 8'h14;
  // Line control fields.
  localparam int LC_WLEN_LO = 0;
  localparam int LC_STOP = 2;
  localparam int LC_PEN = 3;
  localparam int LC_EVEN = 4;
  localparam int LC_DIVACC = 7;
  // Interrupt enable fields.
  localparam int IE_TX_HOLDING_EMPTY_FLAG = 1;
  localparam int IE_LSTAT = 2;
  // Line status fields.
  localparam int LS_READY = 0;
  localparam int LS_OVERRUN = 1;
  localparam int LS_PARITY = 2;
  localparam int LS_FRAMING = 3;
  localparam int LS_BREAK = 4;
  localparam int LS_TX_HOLDING_EMPTY_FLAG = 5;
  localparam int LS_IDLE = 6;
  // Reset values.
  localparam logic [15:0] DIV_RESET = 16'h0001;
  localparam logic [7:0] LCTL_RESET = 8'h03;
  localparam logic [7:0] IEN_RESET = 8'h00;
  // Oversampling: ticks per bit, and the half bit used for sampling.
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] HALF_LAST = 4'h7;
  localparam logic [7:0] TICKS_BIT = 8'h10;
  localparam logic [7:0] TICKS_HALF = 8'h08;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// File: ubl_serial_peer.sv
`timescale 1ns/1ns
`default_nettype none
module ubl_serial_peer (
  input wire logic i_core_clk,
  output logic o_line
);
  // The line idles at mark level between frames.
  initial o_line = 1'b1;
  task automatic hold(input logic lvl, input int n);
    @(posedge i_core_clk);
    o_line <= lvl;
    repeat (n - 1) @(posedge i_core_clk);
  endtask
  // The caller packs start, data, parity and stop bits, lowest first.
  task automatic send(input logic [11:0] b, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      hold(b[i], per);
    end
  endtask
endmodule // ubl_serial_peer
`default_nettype wire

// File: ubl_uart_status.sv
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module ubl_uart_status (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_serial_in,
  output logic o_serial_out,
  output logic o_irq
);
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK
  } ubl_rx_state_t;

  logic [7:0] aw_addr;
  logic [7:0] w_data;
  logic w_lane0;
  logic [7:0] div_lo;
  logic [7:0] div_hi;
  logic [7:0] ien;
  logic [7:0] lctl;
  logic [7:0] tx_holding_reg;
  logic [7:0] rx_buffer_reg;
  logic rx_ready_flag;
  logic overrun_flag;
  logic parity_error_flag;
  logic framing_error_flag;
  logic break_seen_flag;
  logic tx_holding_empty_flag;
  logic tx_idle_flag;
  logic div_reload;
  logic tick;
  logic do_wr;
  logic rd_take;
  logic rd_buffer;
  logic rd_status;
  logic wr_holding;
  logic [7:0] line_status;
  logic divisor_access_bit;
  logic [3:0] nbits;

  assign divisor_access_bit = lctl[ubl_pkg::LC_DIVACC];
  assign nbits = 4'd5 + {2'b00, lctl[ubl_pkg::LC_WLEN_LO +: 2]};
  assign do_wr = !o_awready && !o_wready && !o_bvalid;
  assign rd_take = i_arvalid && o_arready;
  assign rd_buffer = rd_take && !divisor_access_bit
    && i_araddr == ubl_pkg::ADDR_DATA;
  assign rd_status = rd_take && i_araddr == ubl_pkg::ADDR_LSTAT;
  assign wr_holding = do_wr && w_lane0 && !divisor_access_bit
    && aw_addr == ubl_pkg::ADDR_DATA;

  // Bit seven is tied low; the rest mirror live flags.
  assign line_status = {1'b0, tx_idle_flag, tx_holding_empty_flag,
    break_seen_flag, framing_error_flag, parity_error_flag,
    overrun_flag, rx_ready_flag};

  ubl_baud_div #(.WIDTH(16)) u_div (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_divisor({div_hi, div_lo}),
    .i_reload(div_reload),
    .o_tick(tick)
  );

  // Write channel: address and data are taken in either order, then the
  // write happens once both are held and the response follows.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= ubl_pkg::RESP_OKAY;
      aw_addr <= 8'h00;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_addr <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_data <= i_wdata[7:0];
        w_lane0 <= i_wstrb[0];
        o_wready <= 1'b0;
      end
      if (do_wr) begin
        o_bvalid <= 1'b1;
        case (aw_addr)
          ubl_pkg::ADDR_DATA, ubl_pkg::ADDR_IEN, ubl_pkg::ADDR_LCTL,
          ubl_pkg::ADDR_LSTAT: o_bresp <= ubl_pkg::RESP_OKAY;
          default: o_bresp <= ubl_pkg::RESP_SLVERR;
        endcase
      end
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  // Software registers. Writes to the status word are accepted and
  // dropped, since its flags belong to the hardware.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_lo <= ubl_pkg::DIV_RESET[7:0];
      div_hi <= ubl_pkg::DIV_RESET[15:8];
      ien <= ubl_pkg::IEN_RESET;
      lctl <= ubl_pkg::LCTL_RESET;
      div_reload <= 1'b0;
    end else begin
      div_reload <= 1'b0;
      if (do_wr && w_lane0) begin
        case (aw_addr)
          ubl_pkg::ADDR_DATA: begin
            if (divisor_access_bit) begin
              div_lo <= w_data;
              div_reload <= 1'b1;
            end
          end
          ubl_pkg::ADDR_IEN: begin
            if (divisor_access_bit) begin
              div_hi <= w_data;
              div_reload <= 1'b1;
            end else begin
              ien <= {4'h0, w_data[3:0]};
            end
          end
          ubl_pkg::ADDR_LCTL: lctl <= w_data;
          default: ;
        endcase
      end
    end
  end

  // Read channel answers one cycle after the address is taken.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= ubl_pkg::RESP_OKAY;
    end else if (rd_take) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rresp <= ubl_pkg::RESP_OKAY;
      case (i_araddr)
        ubl_pkg::ADDR_DATA: o_rdata <= {24'h00_0000,
          divisor_access_bit ? div_lo : rx_buffer_reg};
        ubl_pkg::ADDR_IEN: o_rdata <= {24'h00_0000,
          divisor_access_bit ? div_hi : ien};
        ubl_pkg::ADDR_LCTL: o_rdata <= {24'h00_0000, lctl};
        ubl_pkg::ADDR_LSTAT: o_rdata <= {24'h00_0000, line_status};
        default: begin
          o_rdata <= 32'h0000_0000;
          o_rresp <= ubl_pkg::RESP_SLVERR;
        end
      endcase
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // Receiver, sampling each bit at its middle on the 16x tick.
  ubl_rx_state_t rx_state;
  logic [3:0] rx_cnt;
  logic [3:0] rx_bitn;
  logic [7:0] rx_shift;
  logic rx_parbit;
  logic rx_load;
  logic [7:0] rx_char;
  logic rx_par_err;
  logic rx_frm_err;
  logic rx_brk;
  logic [7:0] rx_aligned;

  assign rx_aligned = rx_shift >> (4'd8 - nbits);

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_state <= RX_IDLE;
      rx_cnt <= 4'h0;
      rx_bitn <= 4'h0;
      rx_shift <= 8'h00;
      rx_parbit <= 1'b0;
      rx_load <= 1'b0;
      rx_char <= 8'h00;
      rx_par_err <= 1'b0;
      rx_frm_err <= 1'b0;
      rx_brk <= 1'b0;
    end else begin
      rx_load <= 1'b0;
      rx_par_err <= 1'b0;
      rx_frm_err <= 1'b0;
      rx_brk <= 1'b0;
      if (tick) begin
        rx_cnt <= rx_cnt + 4'h1;
        case (rx_state)
          RX_IDLE: begin
            rx_cnt <= 4'h0;
            if (!i_serial_in) begin
              rx_state <= RX_START;
            end
          end
          RX_START: begin
            if (rx_cnt == ubl_pkg::HALF_LAST) begin
              rx_cnt <= 4'h0;
              rx_bitn <= 4'h0;
              // A start that is gone by mid-bit was a glitch.
              rx_state <= i_serial_in ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (rx_cnt == ubl_pkg::TICK_LAST) begin
              rx_shift <= {i_serial_in, rx_shift[7:1]};
              rx_bitn <= rx_bitn + 4'h1;
              if (rx_bitn == nbits - 4'h1) begin
                rx_state <= lctl[ubl_pkg::LC_PEN] ? RX_PAR : RX_STOP;
              end
            end
          end
          RX_PAR: begin
            if (rx_cnt == ubl_pkg::TICK_LAST) begin
              rx_parbit <= i_serial_in;
              rx_state <= RX_STOP;
            end
          end
          RX_STOP: begin
            // Only the first stop bit is examined.
            if (rx_cnt == ubl_pkg::TICK_LAST) begin
              rx_load <= 1'b1;
              rx_char <= rx_aligned;
              rx_par_err <= lctl[ubl_pkg::LC_PEN]
                && ((^rx_aligned ^ rx_parbit) ~^ lctl[ubl_pkg::LC_EVEN]);
              rx_state <= RX_IDLE;
              if (!i_serial_in && rx_aligned == 8'h00
                  && !(lctl[ubl_pkg::LC_PEN] && rx_parbit)) begin
                rx_brk <= 1'b1;
                rx_par_err <= 1'b0;
                // A break also ends on a low stop bit, so it counts as a
                // framing error as well.
                rx_frm_err <= 1'b1;
                rx_cnt <= 4'h0;
                rx_state <= RX_BRK;
              end else if (!i_serial_in) begin
                rx_frm_err <= 1'b1;
                // The low stop bit is taken as the next start bit.
                rx_cnt <= 4'h0;
                rx_state <= RX_START;
              end
            end
          end
          RX_BRK: begin
            // Leave only after the line has been high for half a bit.
            if (i_serial_in == 1'b0) begin
              rx_cnt <= 4'h0;
            end else if (rx_cnt == ubl_pkg::HALF_LAST) begin
              rx_state <= RX_IDLE;
            end
          end
          default: rx_state <= RX_IDLE;
        endcase
      end
    end
  end

  // Receive flags. A new event in the cycle of its clearing read wins.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_buffer_reg <= 8'h00;
      rx_ready_flag <= 1'b0;
      overrun_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      framing_error_flag <= 1'b0;
      break_seen_flag <= 1'b0;
    end else begin
      if (rx_load) begin
        rx_buffer_reg <= rx_char;
        rx_ready_flag <= 1'b1;
      end else if (rd_buffer) begin
        rx_ready_flag <= 1'b0;
      end
      if (rx_load && rx_ready_flag && !rd_buffer) begin
        overrun_flag <= 1'b1;
      end else if (rd_status) begin
        overrun_flag <= 1'b0;
      end
      if (rx_par_err) begin
        parity_error_flag <= 1'b1;
      end else if (rd_status) begin
        parity_error_flag <= 1'b0;
      end
      if (rx_frm_err) begin
        framing_error_flag <= 1'b1;
      end else if (rd_status) begin
        framing_error_flag <= 1'b0;
      end
      if (rx_brk) begin
        break_seen_flag <= 1'b1;
      end else if (rd_status) begin
        break_seen_flag <= 1'b0;
      end
    end
  end

  // Transmitter: holding register feeding a shifter that sends LSB first.
  logic tx_busy;
  logic [3:0] tx_cnt;
  logic [7:0] tx_left;
  logic [11:0] tx_shift;
  logic [11:0] tx_frame;
  logic [7:0] tx_total;
  logic tx_move;

  assign tx_move = !tx_busy && !tx_holding_empty_flag;

  always_comb begin
    logic [7:0] d;
    d = tx_holding_reg & ~(8'hFF << nbits);
    tx_frame = 12'hFFF;
    tx_frame[0] = 1'b0;
    tx_frame[8:1] = d | (8'hFF << nbits);
    if (lctl[ubl_pkg::LC_PEN]) begin
      tx_frame[nbits + 4'h1] = ^d ^ ~lctl[ubl_pkg::LC_EVEN];
    end
    // Ticks in a frame: start, data, parity, then the stop length.
    tx_total = ubl_pkg::TICKS_BIT * (8'd2 + {4'h0, nbits}
      + {7'h00, lctl[ubl_pkg::LC_PEN]});
    if (lctl[ubl_pkg::LC_STOP]) begin
      tx_total = tx_total + ((nbits == 4'd5) ? ubl_pkg::TICKS_HALF
        : ubl_pkg::TICKS_BIT);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_holding_reg <= 8'h00;
      tx_holding_empty_flag <= 1'b1;
      tx_busy <= 1'b0;
      tx_cnt <= 4'h0;
      tx_left <= 8'h00;
      tx_shift <= 12'hFFF;
    end else begin
      if (wr_holding) begin
        tx_holding_reg <= w_data;
        tx_holding_empty_flag <= 1'b0;
      end else if (tx_move) begin
        tx_holding_empty_flag <= 1'b1;
      end
      if (tx_move) begin
        tx_busy <= 1'b1;
        tx_shift <= tx_frame;
        tx_left <= tx_total;
        tx_cnt <= 4'h0;
      end else if (tx_busy && tick) begin
        tx_cnt <= tx_cnt + 4'h1;
        tx_left <= tx_left - 8'h01;
        if (tx_cnt == ubl_pkg::TICK_LAST) begin
          tx_shift <= {1'b1, tx_shift[11:1]};
        end
        if (tx_left == 8'h01) begin
          tx_busy <= 1'b0;
        end
      end
    end
  end

  // Registered outputs: serial line, idle flag and interrupt request.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_serial_out <= 1'b1;
      tx_idle_flag <= 1'b1;
      o_irq <= 1'b0;
    end else begin
      o_serial_out <= tx_busy ? tx_shift[0] : 1'b1;
      tx_idle_flag <= tx_holding_empty_flag && !tx_busy
        && !tx_move && !wr_holding;
      o_irq <= (ien[ubl_pkg::IE_LSTAT] && (overrun_flag
        || parity_error_flag || framing_error_flag || break_seen_flag))
        || (ien[ubl_pkg::IE_TX_HOLDING_EMPTY_FLAG] && tx_holding_empty_flag);
    end
  end
endmodule // ubl_uart_status
`default_nettype wire
